// >>> logic/snc_consts.svh
// Constants of the node configuration strap loader
`ifndef SNC_CONSTS_SVH
`define SNC_CONSTS_SVH
`define SNC_ADDR_W 4
`define SNC_ADDR_MASTER 4'h0
`define SNC_ADDR_RST 4'h0
`define SNC_RATE_W 4
`define SNC_RATE_RST 4'h0
`define SNC_RATE_10M 4'h2
`define SNC_RATE_20M 4'h3
`define SNC_RATE_HI_MSB 3
`define SNC_RATE_HI_LSB 2
`define SNC_SETTLE_NS 1000
`define SNC_CLK_NS 4
`define SNC_SETTLE_CYC ((`SNC_SETTLE_NS + `SNC_CLK_NS - 1) / `SNC_CLK_NS)
`define SNC_CNT_W 8
`endif

// >>> logic/snc_pkg.sv
// Types of the node configuration strap loader
package snc_pkg;
	typedef enum logic [1:0] {SNC_SPEED_NONE, SNC_SPEED_10M, SNC_SPEED_20M} snc_speed_t;
	typedef enum {SNC_SETTLE, SNC_CHECK, SNC_ONLINE, SNC_FAULT} snc_state_t;
endpackage

// >>> logic/snc_decode.sv
// Selector code checker: address and rate validity
`timescale 1ns/1ps
`include "snc_consts.svh"
module snc_decode
(
	// Raw selector codes
	input wire logic [3:0] addr_code,
	input wire logic [3:0] rate_code,
	// Decoded results
	output snc_pkg::snc_speed_t speed,
	output logic addr_ok,
	output logic rate_ok
);
	// Address zero belongs to the master, so a slave never takes it
	always_comb
	begin
		addr_ok = (addr_code != `SNC_ADDR_MASTER);
	end

	// Upper two rate positions must stay off; low codes 0 and 1 are forbidden
	always_comb
	begin
		speed = snc_pkg::SNC_SPEED_NONE;
		if (rate_code == `SNC_RATE_10M)
			speed = snc_pkg::SNC_SPEED_10M;
		else if (rate_code == `SNC_RATE_20M)
			speed = snc_pkg::SNC_SPEED_20M;
		rate_ok = (speed != snc_pkg::SNC_SPEED_NONE);
	end
endmodule

// >>> logic/snc_strap_loader.sv
// Power-on node address and link rate strap loader
`timescale 1ns/1ps
`include "snc_consts.svh"
module snc_strap_loader
(
	// Clock and power-on reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// Selector switches, bit 0 is position 1
	input wire logic [3:0] ADDRESS_SELECTOR_SWITCH,
	input wire logic [3:0] RATE_SELECTOR_SWITCH,
	// Latched configuration
	output logic [3:0] NODE_ADDR,
	output logic RATE_10M,
	output logic RATE_20M,
	output logic CFG_DONE,
	output logic CFG_ERROR,
	output logic NODE_ENABLE
);
	localparam int SETTLE_CYC = `SNC_SETTLE_CYC;

	snc_pkg::snc_state_t state;
	snc_pkg::snc_state_t next_state;
	logic [`SNC_CNT_W-1:0] settle_cnt;
	logic [`SNC_CNT_W-1:0] next_settle_cnt;
	logic [3:0] addr_hold;
	logic [3:0] next_addr_hold;
	logic [3:0] rate_hold;
	logic [3:0] next_rate_hold;
	snc_pkg::snc_speed_t speed;
	logic addr_ok;
	logic rate_ok;
	logic [3:0] node_addr;
	logic [3:0] next_node_addr;
	logic rate_10m;
	logic next_rate_10m;
	logic rate_20m;
	logic next_rate_20m;
	logic cfg_done;
	logic next_cfg_done;
	logic cfg_error;
	logic next_cfg_error;
	logic node_enable;
	logic next_node_enable;

	// Checks the captured codes, not the live switches
	snc_decode u_decode
	(
		.addr_code(addr_hold),
		.rate_code(rate_hold),
		.speed(speed),
		.addr_ok(addr_ok),
		.rate_ok(rate_ok)
	);

	// Let the switch contacts settle after power-up, capture once, then freeze
	always_comb
	begin
		next_state = state;
		next_settle_cnt = settle_cnt;
		next_addr_hold = addr_hold;
		next_rate_hold = rate_hold;
		next_node_addr = node_addr;
		next_rate_10m = rate_10m;
		next_rate_20m = rate_20m;
		next_cfg_done = cfg_done;
		next_cfg_error = cfg_error;
		next_node_enable = node_enable;
		case (state)
			snc_pkg::SNC_SETTLE:
			begin
				if (settle_cnt == `SNC_CNT_W'(SETTLE_CYC - 1))
				begin
					next_addr_hold = ADDRESS_SELECTOR_SWITCH;
					next_rate_hold = RATE_SELECTOR_SWITCH;
					next_state = snc_pkg::SNC_CHECK;
				end
				else
					next_settle_cnt = settle_cnt + `SNC_CNT_W'(1);
			end
			snc_pkg::SNC_CHECK:
			begin
				next_cfg_done = 1'b1;
				if (addr_ok && rate_ok)
				begin
					next_node_addr = addr_hold;
					next_rate_10m = (speed == snc_pkg::SNC_SPEED_10M);
					next_rate_20m = (speed == snc_pkg::SNC_SPEED_20M);
					next_node_enable = 1'b1;
					next_state = snc_pkg::SNC_ONLINE;
				end
				else
				begin
					// A bad strap keeps the node silent rather than risk a clash
					next_cfg_error = 1'b1;
					next_state = snc_pkg::SNC_FAULT;
				end
			end
			// Terminal states: only a new power-on reset leaves them
			snc_pkg::SNC_ONLINE: next_state = state;
			snc_pkg::SNC_FAULT: next_state = state;
			default: next_state = snc_pkg::SNC_SETTLE;
		endcase
	end

	// Registers; reset is the power-on reset
	always_ff @(posedge SYS_CLK)
	begin
		if (SYS_RST)
		begin
			state <= snc_pkg::SNC_SETTLE;
			settle_cnt <= `SNC_CNT_W'h00;
			addr_hold <= `SNC_ADDR_RST;
			rate_hold <= `SNC_RATE_RST;
			node_addr <= `SNC_ADDR_RST;
			rate_10m <= 1'b0;
			rate_20m <= 1'b0;
			cfg_done <= 1'b0;
			cfg_error <= 1'b0;
			node_enable <= 1'b0;
		end
		else
		begin
			state <= next_state;
			settle_cnt <= next_settle_cnt;
			addr_hold <= next_addr_hold;
			rate_hold <= next_rate_hold;
			node_addr <= next_node_addr;
			rate_10m <= next_rate_10m;
			rate_20m <= next_rate_20m;
			cfg_done <= next_cfg_done;
			cfg_error <= next_cfg_error;
			node_enable <= next_node_enable;
		end
	end

	// Outputs straight from flip-flops
	assign NODE_ADDR = node_addr;
	assign RATE_10M = rate_10m;
	assign RATE_20M = rate_20m;
	assign CFG_DONE = cfg_done;
	assign CFG_ERROR = cfg_error;
	assign NODE_ENABLE = node_enable;

	// Checks, all in the single clock domain and quiet during power-on reset

	// An online slave never shows the master's address
	a_no_master_addr: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		NODE_ENABLE |-> NODE_ADDR != `SNC_ADDR_MASTER)
		else $error("Enabled node uses master address");

	// Address frozen once online, whatever the switch does
	a_addr_frozen: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		$past(NODE_ENABLE) |-> $stable(NODE_ADDR))
		else $error("Address changed while powered");

	// Rate frozen once configured
	a_rate_frozen: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		$past(CFG_DONE) |-> $stable(RATE_10M) && $stable(RATE_20M))
		else $error("Rate changed while powered");

	// Exactly one rate while online
	a_rate_onehot: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		NODE_ENABLE |-> RATE_10M != RATE_20M)
		else $error("Enabled node without one rate");

	// Code 0011 gives the fast rate
	a_rate_decode: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == snc_pkg::SNC_CHECK && rate_hold == `SNC_RATE_20M && addr_ok) |=> RATE_20M && !RATE_10M)
		else $error("Code 0011 not 20 Mbps");

	// Code 0010 gives the slow rate
	a_rate_slow_decode: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == snc_pkg::SNC_CHECK && rate_hold == `SNC_RATE_10M && addr_ok) |=> RATE_10M && !RATE_20M)
		else $error("Code 0010 not 10 Mbps");

	// Upper rate positions on must never bring the node up
	a_bad_rate_err: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == snc_pkg::SNC_CHECK && rate_hold[`SNC_RATE_HI_MSB:`SNC_RATE_HI_LSB] != 2'h0)
		|=> CFG_ERROR && !NODE_ENABLE)
		else $error("High rate bits accepted");

	// Any rate code but the two valid ones is refused
	a_bad_code_err: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == snc_pkg::SNC_CHECK && rate_hold != `SNC_RATE_10M && rate_hold != `SNC_RATE_20M)
		|=> CFG_ERROR && !NODE_ENABLE)
		else $error("Forbidden rate code accepted");

	// The master's address on the switch is refused
	a_zero_addr_err: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == snc_pkg::SNC_CHECK && addr_hold == `SNC_ADDR_MASTER) |=> CFG_ERROR && !NODE_ENABLE)
		else $error("Zero address accepted");

	// Error and enable are exclusive
	a_err_excl: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!(CFG_ERROR && NODE_ENABLE))
		else $error("Error and enable together");

	// Once in error, the node stays off until the next power-on
	a_err_sticky: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		CFG_ERROR |=> CFG_ERROR && !NODE_ENABLE)
		else $error("Error flag dropped while powered");

	// An offline node shows no address and no rate
	a_offline_quiet: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!NODE_ENABLE |-> NODE_ADDR == `SNC_ADDR_RST && !RATE_10M && !RATE_20M)
		else $error("Offline node shows configuration");

	// The published address is the captured switch code
	a_addr_source: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		$rose(NODE_ENABLE) |-> NODE_ADDR == $past(addr_hold))
		else $error("Address not from selector");

	// Capture only after the full settle count
	a_settle_wait: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		$rose(state == snc_pkg::SNC_CHECK) |-> settle_cnt == `SNC_CNT_W'(SETTLE_CYC - 1))
		else $error("Switches captured before settle");

	// Done follows the check by one cycle
	a_done_time: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		$rose(state == snc_pkg::SNC_CHECK) |=> CFG_DONE)
		else $error("Done late");

	// Main scenarios
	c_online_10m: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) $rose(NODE_ENABLE) && RATE_10M);
	c_online_20m: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) $rose(NODE_ENABLE) && RATE_20M);
	c_fault: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) $rose(CFG_ERROR));
	c_zero_addr: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) state == snc_pkg::SNC_CHECK && !addr_ok);
	c_switch_moved: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) NODE_ENABLE && ADDRESS_SELECTOR_SWITCH != NODE_ADDR);
endmodule

// >>> bench/snc_master_model.sv
// Far-side master model: decides whether the slave can join its link
`timescale 1ns/1ps
module snc_master_model
(
	// Master rate set by software
	input wire logic master_20m,
	// Slave configuration
	input wire logic [3:0] node_addr,
	input wire logic rate_10m,
	input wire logic rate_20m,
	input wire logic node_enable,
	// Link result
	output logic link_up
);
	// Only a non-master address at the master's own rate can talk
	// Four address bits leave fifteen slave slots beside the master
	// One slave on this link, so its address is unique by construction
	// Link is combinational: it follows every input change, the master rate included, without a slave power-up
	assign link_up = node_enable && (node_addr != 4'h0) && (master_20m ? rate_20m : rate_10m);
endmodule

// >>> bench/tb.sv
// Strap loader testbench
`timescale 1ns/1ps
module tb;
	logic SYS_CLK, SYS_RST, lk, m20, r10, r20, done, err, en;
	logic [3:0] asw, rsw, addr;
	int fails, total_checks;
	int cycles = 0;
	snc_strap_loader dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDRESS_SELECTOR_SWITCH(asw),
		.RATE_SELECTOR_SWITCH(rsw), .NODE_ADDR(addr), .RATE_10M(r10), .RATE_20M(r20),
		.CFG_DONE(done), .CFG_ERROR(err), .NODE_ENABLE(en));
	snc_master_model far (.master_20m(m20), .node_addr(addr), .rate_10m(r10), .rate_20m(r20),
		.node_enable(en), .link_up(lk));
	// Clock, 4 ns period
	initial
	begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end
	// Hang guard, well above the eight power-ups
	always @(posedge SYS_CLK)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			fails++;
			final_report();
		end
	end
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Power cycle with given switches; returns once outputs are valid
	task automatic power_up(input logic [3:0] a, input logic [3:0] r);
		@(posedge SYS_CLK);
		SYS_RST <= 1'b1;
		asw <= a;
		rsw <= r;
		repeat (4) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		repeat (250) @(posedge SYS_CLK);
		#1;
		chk("done early", 4'h0, {3'h0, done});
		@(posedge SYS_CLK);
		#1;
	endtask
	// Flags are {rate 10M, rate 20M, error, enable}
	task automatic expect_cfg(input logic [3:0] ea, input logic [3:0] fl, input logic el);
		chk("addr", ea, addr);
		chk("flags", fl, {r10, r20, err, en});
		chk("done link", {2'h0, 1'b1, el}, {2'h0, done, lk});
	endtask
	// Valid setup holds while switches move, then a power cycle takes new ones
	task automatic scen_hold();
		m20 = 1'b1;
		power_up(4'hF, 4'h3);
		expect_cfg(4'hF, 4'h5, 1'b1);
		@(posedge SYS_CLK);
		asw <= 4'h2;
		rsw <= 4'h2;
		repeat (20) @(posedge SYS_CLK);
		#1;
		expect_cfg(4'hF, 4'h5, 1'b1);
		m20 = 1'b0;
		power_up(4'h2, 4'h2);
		expect_cfg(4'h2, 4'h9, 1'b1);
	endtask
	// Address 0 is the master's and must be refused
	task automatic scen_zero();
		power_up(4'h0, 4'h2);
		expect_cfg(4'h0, 4'h2, 1'b0);
		power_up(4'h1, 4'h2);
		expect_cfg(4'h1, 4'h9, 1'b1);
		m20 = 1'b1;
		#1;
		chk("link wrong rate", 4'h0, {3'h0, lk});
	endtask
	// Forbidden rate codes, including upper positions on
	task automatic scen_bad_rate();
		logic [3:0] codes[4] = '{4'h0, 4'h1, 4'h6, 4'hB};
		foreach (codes[i])
		begin
			power_up(4'h5, codes[i]);
			expect_cfg(4'h0, 4'h2, 1'b0);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		SYS_RST = 1'b1;
		asw = 4'h0;
		rsw = 4'h0;
		m20 = 1'b1;
		fails = 0;
		total_checks = 0;
		scen_hold();
		scen_zero();
		scen_bad_rate();
		final_report();
	end
endmodule
